// ===== dma_dev_model.sv
// Purpose: behavioural disk device at the far side of the dma host port
// Assumes: word k of a transfer is base + k * 0101h
// Notes:   released data lines show a pattern that changes every cycle
`timescale 1ns/1ns
`default_nettype none
module dma_dev_model (
    input  wire logic                     clk,
    input  wire logic                     link_clk,
    input  wire logic                     nrst,
    input  wire logic                     go,
    input  wire logic                     write,
    input  wire logic                     ultra,
    input  wire logic [15:0]              count,
    input  wire logic [15:0]              base,
    input  wire logic [15:0]              susp_at,
    input  wire dma_host_pkg::host_pins_t pins,
    output dma_host_pkg::dev_pins_t       dev
);
    logic [15:0] n, un, ngot, lat, last, pd, ud, bad;
    logic [15:0] got [0:63];
    logic        p_rd, p_wr, stb, drv, req, ack, uin;
    logic [2:0]  hold;
    logic [1:0]  lk;
    assign ack = !pins.dmack_n;
    assign uin = ultra && !write;
    always_comb begin
        dev.dma_req = req;
        dev.iordy   = (ack && uin) ? stb : !(ack && ultra);
        if (ack && !ultra && !write && !pins.iord_n) begin
            dev.data = base + n * 16'h0101;
        end else if (drv) begin
            dev.data = ud;
        end else begin
            dev.data = ~last;
        end
    end
    // word moves on the strobe edge alone, whatever the active/recovery split
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            {req, n, ngot, hold, bad, last, lat, pd} <= '0;
            {p_rd, p_wr} <= 2'b11;
        end else begin
            p_rd <= pins.iord_n;
            p_wr <= pins.iowr_n;
            last <= dev.data;
            pd   <= pins.data;
            if (!pins.iowr_n) lat <= pins.data;
            if (hold != 3'd0) hold <= hold - 3'd1;
            req <= go && hold == 3'd0 && (uin ? un : n) < count
                   && !(ack && ultra && pins.iowr_n);
            if (!go) begin
                n    <= 16'h0000;
                ngot <= 16'h0000;
            end else if (ack && !ultra && (write ? (pins.iowr_n && !p_wr)
                                                 : (pins.iord_n && !p_rd))) begin
                n <= n + 16'h0001;
                if (write) got[ngot[5:0]] <= lat;
                if (write) ngot <= ngot + 16'h0001;
                if (n + 16'h0001 == susp_at) hold <= 3'd6;
            end else if (ack && ultra && write && !pins.iowr_n && pins.iord_n != p_rd) begin
                got[ngot[5:0]] <= pins.data;
                ngot <= ngot + 16'h0001;
                n    <= n + 16'h0001;
                if (pins.data !== pd) bad <= bad + 16'h0001;
            end
        end
    end
    // device strobe for data-in, paused while host ready is negated
    always_ff @(posedge link_clk or negedge nrst) begin
        if (!nrst) begin
            {un, lk, drv, ud} <= '0;
            stb <= 1'b1;
        end else if (!(go && uin && ack && !pins.iowr_n)) begin
            drv <= 1'b0;
            lk  <= 2'd0;
            stb <= 1'b1;
            if (!go) un <= 16'h0000;
        end else if (!pins.iord_n && un < count) begin
            lk  <= lk + 2'd1;
            drv <= 1'b1;
            if (lk == 2'd0) ud <= base + un * 16'h0101;
            if (lk == 2'd3) stb <= !stb;
            if (lk == 2'd3) un <= un + 16'h0001;
        end
    end
endmodule
`default_nettype wire

// ===== dma_host.sv
// Purpose: host end of the disk-emulation dma data port, multiword and ultra dma
// Assumes: device strobe arrives on link_clk domain (sampled there), 10 MHz clk
// Notes:   ultra data-in only captures on device strobe; data-out drives host strobe
`timescale 1ns/1ns
`default_nettype none
`include "dma_host_consts.svh"
module dma_host #(
    parameter int MAX_MODE = `UD_MAX_MODE
) (
    input  wire logic                   clk,
    input  wire logic                   nrst,
    input  wire logic                   link_clk,
    input  wire dma_host_pkg::xfer_cmd_t cmd,
    input  wire logic                   cmd_valid,
    output logic                        cmd_ready,
    input  wire logic [15:0]            wr_data,
    output logic                        wr_take,
    output logic [15:0]                 rd_data,
    output logic                        rd_valid,
    input  wire logic                   rd_ready,
    output logic                        done,
    output logic                        early_end,
    input  wire logic                   dev_intrq,
    output logic                        host_intrq,
    input  wire dma_host_pkg::dev_pins_t dev,
    output dma_host_pkg::host_pins_t    pins
);
    dma_host_pkg::host_state_t state;
    logic        rst_a, rst_n;
    logic [1:0]  rq_s, rdy_s;
    logic [15:0] cnt, remain;
    logic [7:0]  tmr;
    logic        write, ultra, strobe;
    logic [15:0] crc, dout;
    logic [2:0]  mode;
    logic [1:0]  wp, rp;
    logic [2:0]  fill;
    logic [15:0] mem_q;
    logic        lk_tog, lk_s0, lk_s1, lk_s2;
    logic [15:0] lk_data, lk_d0, lk_d1, d_s0, d_s1;
    logic [15:0] lk_buf [4];
    logic [1:0]  lk_wp, lk_rp, rd_addr;
    logic        lk_r0, lk_r1, lk_r2, lk_en0, lk_en1;
    logic        cap_q, pop, mw_cap, st_we;
    logic        stop_req;
    logic        rq_now, rdy_now, cap_ev, pause_cap, pause_lim;

    initial begin
        if (MAX_MODE < 0 || MAX_MODE > `UD_MAX_MODE)
            $error("dma_host max mode out of range");
    end

    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [15:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 15; i >= 0; i--)
            r = (r[15] ^ d[i]) ? ({r[14:0], 1'b0} ^ `CRC_POLY) : {r[14:0], 1'b0};
        return r;
    endfunction

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_a <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_a <= 1'b1;
            rst_n <= rst_a;
        end
    end

    // pin synchronisers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rq_s  <= 2'h0;
            rdy_s <= 2'h0;
            d_s0  <= 16'h0000;
            d_s1  <= 16'h0000;
        end else begin
            rq_s  <= {rq_s[0], dev.dma_req};
            rdy_s <= {rdy_s[0], dev.iordy};
            d_s0  <= dev.data;
            d_s1  <= d_s0;
        end
    end
    assign rq_now  = rq_s[1];
    assign rdy_now = rdy_s[1];

    // device strobe edges capture data in link domain; each edge one word
    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            lk_r0  <= 1'b1;
            lk_r1  <= 1'b1;
            lk_r2  <= 1'b1;
            lk_d0  <= 16'h0000;
            lk_d1  <= 16'h0000;
            lk_en0 <= 1'b0;
            lk_en1 <= 1'b0;
            lk_tog <= 1'b0;
            lk_wp  <= 2'h0;
        end else begin
            lk_r0  <= dev.iordy;
            lk_r1  <= lk_r0;
            lk_r2  <= lk_r1;
            lk_d0  <= dev.data;
            lk_d1  <= lk_d0;
            lk_en0 <= !pins.dmack_n && !write && !pins.iowr_n;
            lk_en1 <= lk_en0;
            if (lk_r2 != lk_r1 && lk_en1) begin
                lk_tog <= ~lk_tog;
                lk_wp  <= lk_wp + 2'h1;
            end
        end
    end
    // words wait here until the slower clock side has seen their toggle
    always_ff @(posedge link_clk) begin
        if (lk_r2 != lk_r1 && lk_en1)
            lk_buf[lk_wp] <= lk_d1;
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lk_s0 <= 1'b0;
            lk_s1 <= 1'b0;
            lk_s2 <= 1'b0;
        end else begin
            lk_s0 <= lk_tog;
            lk_s1 <= lk_s0;
            lk_s2 <= lk_s1;
        end
    end
    // one toggle per captured word; late words after stop still counted
    assign cap_ev    = lk_s2 != lk_s1;
    assign mw_cap    = state == dma_host_pkg::ST_ACT && tmr == 8'h00 && !write;
    assign st_we     = cap_ev || mw_cap;
    assign lk_data   = mw_cap ? d_s1 : lk_buf[lk_rp];
    // a word written last edge is not yet in the registered read data
    assign pop       = fill != 3'h0 && !(fill == 3'h1 && cap_q) && (!rd_valid || rd_ready);
    assign rd_addr   = pop ? rp + 2'h1 : rp;
    assign pause_lim = (mode >= 3'(`UD_FAST_MODE_MIN)) ? 1'b1 : 1'b0;
    assign pause_cap = fill >= (pause_lim ? 3'(`UD_PAUSE_FAST) : 3'(`UD_PAUSE_SLOW)) - 3'h1;

    dma_word_store #(.WIDTH(16), .DEPTH(`PAUSE_DEPTH)) u_store (
        .clk  (clk),
        .we   (st_we),
        .waddr(wp),
        .wdata(lk_data),
        .raddr(rd_addr),
        .rdata(mem_q)
    );

    // pause buffer pointers: room for overrun words after host ready drops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp   <= 2'h0;
            rp   <= 2'h0;
            fill <= 3'h0;
            rd_valid <= 1'b0;
            rd_data  <= 16'h0000;
            cap_q    <= 1'b0;
            lk_rp    <= 2'h0;
        end else begin
            cap_q <= st_we;
            if (st_we)
                wp <= wp + 2'h1;
            if (cap_ev)
                lk_rp <= lk_rp + 2'h1;
            if (pop)
                rp <= rp + 2'h1;
            fill <= fill + {2'h0, st_we} - {2'h0, pop};
            if (pop) begin
                rd_valid <= 1'b1;
                rd_data  <= mem_q;
            end else if (rd_ready) begin
                rd_valid <= 1'b0;
            end
        end
    end

    assign cmd_ready = state == dma_host_pkg::ST_IDLE;
    assign wr_take   = write && ((state == dma_host_pkg::ST_ACT && tmr == 8'h00)
                     || (state == dma_host_pkg::ST_UXFER && strobe == 1'b1 && tmr == 8'h00
                         && !rdy_now && remain != 16'h0000 && !stop_req));

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= dma_host_pkg::ST_IDLE;
            cnt <= 16'h0000;
            remain <= 16'h0000;
            tmr <= 8'h00;
            write <= 1'b0;
            ultra <= 1'b0;
            mode <= 3'h0;
            strobe <= 1'b1;
            crc <= `CRC_INIT;
            dout <= 16'h0000;
            stop_req <= 1'b0;
            done <= 1'b0;
            early_end <= 1'b0;
            pins <= '{dmack_n: 1'b1, iord_n: 1'b1, iowr_n: 1'b1, data_oe: 1'b0, data: 16'h0000};
        end else begin
            done <= 1'b0;
            early_end <= 1'b0;
            if (tmr != 8'h00)
                tmr <= tmr - 8'h01;
            unique case (state)
                dma_host_pkg::ST_IDLE: begin
                    if (cmd_valid) begin
                        write  <= cmd.write;
                        ultra  <= cmd.ultra;
                        mode   <= (cmd.mode > 3'(MAX_MODE)) ? 3'(MAX_MODE) : cmd.mode;
                        remain <= cmd.count;
                        state  <= dma_host_pkg::ST_WAITRQ;
                    end
                end
                dma_host_pkg::ST_WAITRQ: begin
                    if (rq_now) begin
                        pins.dmack_n <= 1'b0;
                        crc <= `CRC_INIT;
                        strobe <= 1'b1;
                        stop_req <= 1'b0;
                        if (ultra) begin
                            pins.iowr_n <= 1'b0;
                            pins.iord_n <= write ? 1'b1 : 1'b0;
                            pins.data_oe <= write;
                            tmr <= 8'h01;
                            state <= dma_host_pkg::ST_UXFER;
                        end else begin
                            tmr <= 8'(`MW_ACTIVE_CYC) - 8'h01;
                            cnt <= 16'(`MW_CYCLE_CYC);
                            pins.data_oe <= write;
                            if (write)
                                pins.iowr_n <= 1'b0;
                            else
                                pins.iord_n <= 1'b0;
                            state <= dma_host_pkg::ST_ACT;
                        end
                    end
                end
                dma_host_pkg::ST_ACT: begin
                    cnt <= cnt - 16'h0001;
                    if (write)
                        pins.data <= wr_data;
                    if (tmr == 8'h00) begin
                        pins.iord_n <= 1'b1;
                        pins.iowr_n <= 1'b1;
                        remain <= remain - 16'h0001;
                        tmr <= 8'(`MW_RECOVER_CYC) - 8'h01;
                        state <= dma_host_pkg::ST_REC;
                    end
                end
                dma_host_pkg::ST_REC: begin
                    if (cnt != 16'h0000)
                        cnt <= cnt - 16'h0001;
                    if (tmr == 8'h00 && cnt <= 16'h0001) begin
                        if (remain == 16'h0000) begin
                            pins.dmack_n <= 1'b1;
                            pins.data_oe <= 1'b0;
                            done <= 1'b1;
                            state <= dma_host_pkg::ST_IDLE;
                        end else if (!rq_now) begin
                            pins.dmack_n <= 1'b1;
                            pins.data_oe <= 1'b0;
                            state <= dma_host_pkg::ST_WAITRQ;
                        end else begin
                            tmr <= 8'(`MW_ACTIVE_CYC) - 8'h01;
                            cnt <= 16'(`MW_CYCLE_CYC);
                            if (write)
                                pins.iowr_n <= 1'b0;
                            else
                                pins.iord_n <= 1'b0;
                            state <= dma_host_pkg::ST_ACT;
                        end
                    end
                end
                dma_host_pkg::ST_UXFER: begin
                    if (write && wr_take) begin
                        pins.data <= wr_data;
                        crc <= crc_step(crc, wr_data);
                        tmr <= 8'h01;
                        strobe <= 1'b0;
                    end else if (write && strobe == 1'b0 && tmr == 8'h00) begin
                        pins.iord_n <= ~pins.iord_n;
                        remain <= remain - 16'h0001;
                        strobe <= 1'b1;
                        tmr <= 8'h01;
                    end
                    if (!write)
                        pins.iord_n <= pause_cap ? 1'b1 : 1'b0;
                    if (remain == 16'h0000 || !rq_now) begin
                        pins.iowr_n <= 1'b1;
                        stop_req <= 1'b1;
                        state <= dma_host_pkg::ST_UTERM;
                    end
                end
                dma_host_pkg::ST_UTERM: begin
                    if (!write)
                        pins.iord_n <= 1'b1;
                    if (write && !pins.iord_n)
                        pins.iord_n <= 1'b1;
                    if (!rq_now) begin
                        pins.data_oe <= 1'b1;
                        pins.data <= crc;
                        tmr <= 8'h02;
                        state <= dma_host_pkg::ST_UCRC;
                    end
                end
                dma_host_pkg::ST_UCRC: begin
                    if (tmr == 8'h00) begin
                        pins.dmack_n <= 1'b1;
                        pins.data_oe <= 1'b0;
                        pins.iowr_n <= 1'b1;
                        pins.iord_n <= 1'b1;
                        state <= dma_host_pkg::ST_DONE;
                    end
                end
                dma_host_pkg::ST_DONE: begin
                    if (remain == 16'h0000) begin
                        done <= 1'b1;
                        state <= dma_host_pkg::ST_IDLE;
                    end else begin
                        early_end <= 1'b1;
                        state <= dma_host_pkg::ST_WAITRQ;
                    end
                end
                default: state <= dma_host_pkg::ST_IDLE;
            endcase
            if (cap_ev) begin
                crc <= crc_step(crc, lk_data);
                remain <= remain - 16'h0001;
            end
        end
    end

    // device interrupt always passed on, early ends included
    assign host_intrq = dev_intrq;

    a_ack_after_req: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(pins.dmack_n) |-> $past(rq_now))
        else $error("acknowledge without request");
    a_mw_active_width: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(pins.iord_n) && ultra == 1'b0 && state == dma_host_pkg::ST_ACT
        |-> !pins.iord_n [*2])
        else $error("multiword strobe too short");
    a_ack_held_term: assert property (@(posedge clk) disable iff (!rst_n)
        state == dma_host_pkg::ST_UTERM |-> !pins.dmack_n)
        else $error("acknowledge dropped during termination");
    a_stop_on_end: assert property (@(posedge clk) disable iff (!rst_n)
        state == dma_host_pkg::ST_UXFER && remain == 16'h0000 |=> pins.iowr_n)
        else $error("stop not raised at end");
    a_lines_restore: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(pins.dmack_n) |-> pins.iowr_n && pins.iord_n && !pins.data_oe)
        else $error("lines not restored");
    a_sender_owns: assert property (@(posedge clk) disable iff (!rst_n)
        state == dma_host_pkg::ST_UXFER |-> pins.data_oe == write)
        else $error("data ownership wrong");
    a_data_before_edge: assert property (@(posedge clk) disable iff (!rst_n)
        $changed(pins.iord_n) && write && state == dma_host_pkg::ST_UXFER
        |-> $stable(pins.data))
        else $error("data changed with strobe");
    a_mode_limit: assert property (@(posedge clk) disable iff (!rst_n)
        state != dma_host_pkg::ST_IDLE |-> mode <= 3'(MAX_MODE))
        else $error("mode above maximum");
    c_mw_cycle: cover property (@(posedge clk) state == dma_host_pkg::ST_REC);
    c_ultra_in: cover property (@(posedge clk) cap_ev);
    c_crc_sent: cover property (@(posedge clk) state == dma_host_pkg::ST_UCRC);
    c_early: cover property (@(posedge clk) early_end);
endmodule
`default_nettype wire

// ===== dma_host_consts.svh
// Purpose: constants for the disk-emulation dma host controller
// Assumes: 10 MHz system clock (100 ns)
// Notes:   times in ns, cycle counts derived from them
`ifndef DMA_HOST_CONSTS_SVH
`define DMA_HOST_CONSTS_SVH
`define CLK_PERIOD_NS      100
`define MW_CYCLE_NS        480
`define MW_ACTIVE_NS       215
`define MW_RECOVER_NS      50
`define MW_ACTIVE_CYC      ((`MW_ACTIVE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MW_RECOVER_CYC     ((`MW_RECOVER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MW_CYCLE_CYC       ((`MW_CYCLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define UD_PAUSE_SLOW      2
`define UD_PAUSE_FAST      3
`define UD_FAST_MODE_MIN   3
`define UD_MAX_MODE        6
`define CRC_INIT           16'h4ABA
`define CRC_POLY           16'h1021
`define PAUSE_DEPTH        4
`endif

// ===== dma_host_pkg.sv
// Purpose: types for the dma host controller
// Assumes: nothing
// Notes:   pin groups carried as packed structs
package dma_host_pkg;
    typedef struct packed {
        logic        dma_req;
        logic        iordy;     // ultra: device strobe or device ready
        logic [15:0] data;
    } dev_pins_t;
    typedef struct packed {
        logic        dmack_n;
        logic        iord_n;    // ultra: host ready / host strobe
        logic        iowr_n;    // ultra: stop
        logic        data_oe;
        logic [15:0] data;
    } host_pins_t;
    typedef struct packed {
        logic        write;
        logic        ultra;
        logic [2:0]  mode;
        logic [15:0] count;
    } xfer_cmd_t;
    typedef enum logic [7:0] {
        ST_IDLE   = 8'h01,
        ST_WAITRQ = 8'h02,
        ST_ACT    = 8'h04,
        ST_REC    = 8'h08,
        ST_UXFER  = 8'h10,
        ST_UTERM  = 8'h20,
        ST_UCRC   = 8'h40,
        ST_DONE   = 8'h80
    } host_state_t;
endpackage

// ===== dma_word_store.sv
// Purpose: small word store holding pause-overrun words
// Assumes: single clock, registered read
// Notes:   depth must be a power of two
`timescale 1ns/1ns
`default_nettype none
module dma_word_store #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input  wire logic                     clk,
    input  wire logic                     we,
    input  wire logic [$clog2(DEPTH)-1:0] waddr,
    input  wire logic [WIDTH-1:0]         wdata,
    input  wire logic [$clog2(DEPTH)-1:0] raddr,
    output logic      [WIDTH-1:0]         rdata
);
    logic [WIDTH-1:0] mem [DEPTH];
    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
            $error("dma_word_store depth must be a power of two");
    end
    always_ff @(posedge clk) begin
        if (we)
            mem[waddr] <= wdata;
        rdata <= mem[raddr];
    end
endmodule
`default_nettype wire

// ===== tb.sv
// Purpose: self-checking bench for the dma host controller
// Assumes: device model on the far side, link clock from the bench
// Notes:   random counts and modes from a fixed seed, corners first
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic clk = 0, link_clk = 0, nrst = 0, cmd_valid = 0, rd_ready = 0, dev_intrq = 0;
    logic go = 0, wr = 0, ul = 0, p_ack = 1, p_stb = 1, mw_s, w, u;
    logic [15:0] wr_data = 0, base = 0, cnt = 0, susp = 0, widx = 0, ridx = 0, c;
    logic        cmd_ready, wr_take, rd_valid, done, early_end, host_intrq;
    logic [15:0] rd_data;
    dma_host_pkg::xfer_cmd_t  cmd = '0;
    dma_host_pkg::dev_pins_t  dev;
    dma_host_pkg::host_pins_t pins;
    int n_fail = 0, compares = 0, lo = 0, cyc = 99, i;
    dma_host #(.MAX_MODE(6)) dma_host_i (.clk(clk), .nrst(nrst), .link_clk(link_clk),
        .cmd(cmd), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .wr_data(wr_data),
        .wr_take(wr_take), .rd_data(rd_data), .rd_valid(rd_valid), .rd_ready(rd_ready),
        .done(done), .early_end(early_end), .dev_intrq(dev_intrq),
        .host_intrq(host_intrq), .dev(dev), .pins(pins));
    dma_dev_model dma_dev_model_i (.clk(clk), .link_clk(link_clk), .nrst(nrst), .go(go),
        .write(wr), .ultra(ul), .count(cnt), .base(base), .susp_at(susp), .pins(pins),
        .dev(dev));
    always #50 clk = ~clk;
    initial begin
        #7;
        forever #16 link_clk = ~link_clk;
    end
    function automatic logic [15:0] word_at(input logic [15:0] b, input logic [15:0] k);
        return b + k * 16'h0101;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %0t %s: got %h want %h", $time, what, seen, exp);
        end
    endtask
    task automatic complete_run;
        if (n_fail == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    always @(posedge clk) begin
        rd_ready  <= ($urandom_range(0, 3) != 0);
        dev_intrq <= 1'($urandom_range(0, 1));
        if (wr_take) widx <= widx + 16'h0001;
        wr_data <= word_at(base, wr_take ? widx + 16'h0001 : widx);
    end
    // multiword strobe, high when no multiword cycle is running
    assign mw_s = (ul || pins.dmack_n) ? 1'b1 : (wr ? pins.iowr_n : pins.iord_n);
    always @(posedge clk) begin
        if (nrst) begin
            check(host_intrq, dev_intrq, "interrupt pass");
            if (p_ack && !pins.dmack_n) check(dev.dma_req, 1, "ack without request");
            if (cmd_ready) check({pins.iord_n, pins.iowr_n, pins.data_oe, pins.dmack_n},
                                 4'b1101, "idle pins");
            if (!ul && !wr && !pins.dmack_n) check(pins.data_oe, 0, "read drive");
            if (mw_s && !p_stb) check(lo >= 3, 1, "active width");
            if (!mw_s && p_stb) check(cyc >= 5, 1, "cycle time");
            if (mw_s) lo = 0;
            else lo++;
            if (!mw_s && p_stb) cyc = 0;
            cyc++;
            if (rd_valid && rd_ready) begin
                check(rd_data, word_at(base, ridx), "read word");
                ridx++;
            end
        end
        p_ack = pins.dmack_n;
        p_stb = mw_s;
    end
    task automatic start(input logic tw, input logic tu, input logic [2:0] m,
                         input logic [15:0] tc, input logic [15:0] s);
        @(posedge clk);
        wr <= tw;
        ul <= tu;
        cnt <= tc;
        susp <= s;
        base <= 16'($urandom);
        widx <= 16'h0000;
        ridx = 16'h0000;
        cmd <= '{write: tw, ultra: tu, mode: m, count: tc};
        cmd_valid <= 1'b1;
        @(posedge clk);
        cmd_valid <= 1'b0;
        go <= 1'b1;
        @(posedge clk);
        check(cmd_ready, 0, "busy refuses");
    endtask
    task automatic run(input logic tw, input logic tu, input logic [2:0] m,
                       input logic [15:0] tc, input logic [15:0] s);
        int t;
        start(tw, tu, m, tc, s);
        t = 0;
        while (done !== 1'b1 && t < 4000) begin
            @(posedge clk);
            t++;
        end
        while (!tw && ridx < tc && t < 4000) begin
            @(posedge clk);
            t++;
        end
        check(t < 4000, 1, "done timeout");
        repeat (8) @(posedge clk);
        check(tw ? dma_dev_model_i.ngot : ridx, tc, "word count");
        for (t = 0; t < tc; t++)
            if (tw) check(dma_dev_model_i.got[t], word_at(base, 16'(t)), "write word");
        check(dma_dev_model_i.bad, 0, "data before strobe");
        check({pins.dmack_n, pins.iord_n, pins.iowr_n, pins.data_oe}, 4'b1110, "end");
        go <= 1'b0;
        @(posedge clk);
    endtask
    initial begin
        void'($urandom(32'hD2BB));
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        for (i = 0; i < 16; i++) begin
            w = i[0];
            u = i[1];
            c = (u && !w) ? 16'(2 * $urandom_range(1, 5)) : 16'($urandom_range(1, 9));
            if (i < 2) c = 16'd1;
            if (i == 4 || i == 5) c = 16'd6;
            run(w, u, i < 4 ? (u ? 3'd7 : 3'd0) : 3'($urandom_range(0, u ? 7 : 4)), c,
                (i == 4 || i == 5) ? 16'd2 : 16'd0);
        end
        // hard reset in the middle of a multiword read
        start(1'b0, 1'b0, 3'd0, 16'd20, 16'd0);
        repeat (30) @(posedge clk);
        nrst <= 1'b0;
        go <= 1'b0;
        repeat (3) @(posedge clk);
        check({cmd_ready, pins.dmack_n, pins.iord_n, pins.iowr_n, pins.data_oe},
              5'b11110, "reset idle");
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        run(1'b1, 1'b1, 3'd2, 16'd5, 16'd0);
        complete_run;
    end
    initial begin
        #(100 * 60000);
        check(0, 1, "watchdog");
        complete_run;
    end
endmodule
`default_nettype wire
